// ---- ppm_pkg.sv ----
package ppm_pkg;

  // clock and self-timed write duration
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WRITE_TIME_NS = 3700000; // 3.7 ms
  localparam int unsigned WRITE_CYC_DEF =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TMR_W         = 20;

  // memory geometry defaults
  localparam int FLASH_AW_DEF   = 12;
  localparam int PAGE_AW_DEF    = 5;
  localparam int EE_AW_DEF      = 9;
  localparam int EE_PAGE_AW_DEF = 2;

  // action select coding for the load strobe
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  // command byte coding
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // erased contents and signature row addressing
  localparam logic [7:0]  BYTE_ERASED = 8'hff;
  localparam logic [15:0] WORD_ERASED = 16'hffff;
  localparam logic [7:0]  SIG_ADDR0   = 8'h00;
  localparam logic [7:0]  SIG_ADDR1   = 8'h01;
  localparam logic [7:0]  SIG_ADDR2   = 8'h02;
  localparam logic [7:0]  CAL_ADDR    = 8'h00;

  typedef logic [7:0] ppm_byte_t;

  typedef enum logic {PH_READY, PH_BUSY} ppm_phase_e;

  // programming pins as one bundle for the synchroniser
  typedef struct packed {
    logic       load_strobe;
    logic       page_load_pulse;
    logic       write_strobe_n;
    logic       output_enable_n;
    logic       byte_select_one;
    logic       byte_select_two;
    logic       action_select_hi;
    logic       action_select_lo;
    logic [7:0] data;
  } ppm_pins_s;

  localparam ppm_pins_s PINS_IDLE = '{
    load_strobe: 1'b0, page_load_pulse: 1'b0, write_strobe_n: 1'b1,
    output_enable_n: 1'b1, byte_select_one: 1'b0, byte_select_two: 1'b0,
    action_select_hi: 1'b1, action_select_lo: 1'b1, data: 8'h00};

endpackage

// ---- ppm_port.sv ----
`timescale 1ns/1ps
module ppm_port
  import ppm_pkg::*;
#(
  parameter int          FLASH_AW   = ppm_pkg::FLASH_AW_DEF,
  parameter int          PAGE_AW    = ppm_pkg::PAGE_AW_DEF,
  parameter int          EE_AW      = ppm_pkg::EE_AW_DEF,
  parameter int          EE_PAGE_AW = ppm_pkg::EE_PAGE_AW_DEF,
  parameter int unsigned WRITE_CYC  = ppm_pkg::WRITE_CYC_DEF,
  parameter logic [7:0]  SIG_BYTE0  = 8'h5a, // arbitrary value
  parameter logic [7:0]  SIG_BYTE1  = 8'h01, // arbitrary value
  parameter logic [7:0]  SIG_BYTE2  = 8'h02, // arbitrary value
  parameter logic [7:0]  CAL_BYTE   = 8'h80
)(
  // clock, reset, enable
  input  wire logic               CLK,
  input  wire logic               RESET_N,
  input  wire logic               CE,
  // programming strobes and selects
  input  wire logic               LOAD_STROBE,
  input  wire logic               PAGE_LOAD_PULSE,
  input  wire logic               WRITE_STROBE_N,
  input  wire logic               OUTPUT_ENABLE_N,
  input  wire logic               BYTE_SELECT_ONE,
  input  wire logic               BYTE_SELECT_TWO,
  input  wire logic               ACTION_SELECT_HI,
  input  wire logic               ACTION_SELECT_LO,
  // data bus, split into its three signals
  input  wire ppm_pkg::ppm_byte_t DATA_IN,
  output      ppm_pkg::ppm_byte_t DATA_OUT,
  output      logic               DATA_OE_N,
  // status
  output      logic               READY_BUSY
);

  localparam int PAGE_WORDS = 1 << PAGE_AW;
  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int EE_PAGE = 1 << EE_PAGE_AW;
  localparam int EE_BYTES = 1 << EE_AW;

  typedef struct packed {
    ppm_pins_s                         s1;
    ppm_pins_s                         s2;
    ppm_pins_s                         s3;
    ppm_pins_s                         stab;
    logic [7:0]                        cmd;
    logic [7:0]                        addr_lo;
    logic [7:0]                        addr_hi;
    logic [7:0]                        data_lo;
    logic [7:0]                        data_hi;
    logic [7:0]                        fuse_lo;
    logic [7:0]                        fuse_hi;
    logic [7:0]                        lock;
    logic [PAGE_WORDS-1:0][15:0]       fbuf;
    logic [PAGE_WORDS-1:0]             fmask;
    logic [EE_PAGE-1:0][7:0]           ebuf;
    logic [EE_PAGE-1:0]                emask;
    logic [FLASH_WORDS-1:0][15:0]      flash;
    logic [EE_BYTES-1:0][7:0]          ee;
    ppm_phase_e                        phase;
    logic [TMR_W-1:0]                  tmr;
    logic [7:0]                        dout;
    logic                              doe_n;
  } ppm_state_s;

  ppm_state_s r_r;
  ppm_state_s r_nxt;
  ppm_pins_s  pins;
  ppm_pins_s  agree;
  logic       ls_rise;
  logic       pl_rise;
  logic       wr_fall;
  logic       idle;
  logic [1:0] act;
  logic [15:0] addr;
  logic [15:0] fword;
  logic [7:0]  ebyte;
  logic [7:0]  rd_byte;

  // word address made of both address bytes
  function automatic logic [15:0] full_addr(input logic [7:0] hi,
                                            input logic [7:0] lo);
    full_addr = {hi, lo};
  endfunction

  // a pin edge counts only once the second and third stages agree
  function automatic logic pin_rise(input logic a, input logic b,
                                    input logic s);
    pin_rise = (a == b) && b && !s;
  endfunction

  // bundle the raw pins for the three-stage synchroniser
  assign pins = '{load_strobe: LOAD_STROBE, page_load_pulse: PAGE_LOAD_PULSE,
                  write_strobe_n: WRITE_STROBE_N,
                  output_enable_n: OUTPUT_ENABLE_N,
                  byte_select_one: BYTE_SELECT_ONE,
                  byte_select_two: BYTE_SELECT_TWO,
                  action_select_hi: ACTION_SELECT_HI,
                  action_select_lo: ACTION_SELECT_LO, data: DATA_IN};

  // edge events, taken from the agreed stages; gated off while busy
  assign agree = r_r.s3;
  assign idle = (r_r.phase == PH_READY);
  assign ls_rise = idle && pin_rise(r_r.s2.load_strobe,
                                    r_r.s3.load_strobe, r_r.stab.load_strobe);
  assign pl_rise = idle && pin_rise(r_r.s2.page_load_pulse,
                                    r_r.s3.page_load_pulse,
                                    r_r.stab.page_load_pulse);
  assign wr_fall = idle && pin_rise(!r_r.s2.write_strobe_n,
                                    !r_r.s3.write_strobe_n,
                                    !r_r.stab.write_strobe_n);
  assign act = {agree.action_select_hi, agree.action_select_lo};
  assign addr = full_addr(r_r.addr_hi, r_r.addr_lo);
  assign fword = r_r.flash[addr[FLASH_AW-1:0]];
  assign ebyte = r_r.ee[addr[EE_AW-1:0]];

  // read multiplexer, steered by the settled select levels
  always_comb
  begin
    rd_byte = BYTE_ERASED;
    case (r_r.cmd)
      CMD_RD_FLASH:
        rd_byte = r_r.stab.byte_select_one ? fword[15:8] : fword[7:0];
      CMD_RD_EE:
        if (!r_r.stab.byte_select_one)
          rd_byte = ebyte;
      CMD_RD_FUSE:
        case ({r_r.stab.byte_select_two, r_r.stab.byte_select_one})
          2'b00:   rd_byte = r_r.fuse_lo;
          2'b11:   rd_byte = r_r.fuse_hi;
          2'b01:   rd_byte = r_r.lock;
          default: rd_byte = BYTE_ERASED;
        endcase
      CMD_RD_SIG:
        if (r_r.stab.byte_select_one)
        begin
          if (r_r.addr_lo == CAL_ADDR)
            rd_byte = CAL_BYTE;
        end
        else
        begin
          case (r_r.addr_lo)
            SIG_ADDR0: rd_byte = SIG_BYTE0;
            SIG_ADDR1: rd_byte = SIG_BYTE1;
            SIG_ADDR2: rd_byte = SIG_BYTE2;
            default:   rd_byte = BYTE_ERASED;
          endcase
        end
      default: rd_byte = BYTE_ERASED;
    endcase
  end

  // next state of the whole port
  always_comb
  begin
    logic [FLASH_AW-1:0] fidx;
    logic [EE_AW-1:0]    eidx;
    fidx = '0;
    eidx = '0;
    r_nxt = r_r;
    // three stages; only the second reads the first
    r_nxt.s1 = pins;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    // each pin settles on its own, so one moving pin cannot hold
    // back another pin's edge and make that edge count twice
    r_nxt.stab = ppm_pins_s'((r_r.stab & (r_r.s2 ^ r_r.s3))
                             | (r_r.s3 & ~(r_r.s2 ^ r_r.s3)));
    // loads on the load strobe, register values persist otherwise
    if (ls_rise)
    begin
      case (act)
        ACT_CMD:
          if (!agree.byte_select_one)
          begin
            r_nxt.cmd = agree.data;
            if (agree.data == CMD_NOP)
            begin
              r_nxt.fmask = '0;
              r_nxt.emask = '0;
            end
          end
        ACT_ADDR:
          if (agree.byte_select_one)
            r_nxt.addr_hi = agree.data;
          else
            r_nxt.addr_lo = agree.data;
        ACT_DATA:
          if (agree.byte_select_one)
            r_nxt.data_hi = agree.data;
          else
            r_nxt.data_lo = agree.data;
        default: ;
      endcase
    end
    // page load latches both data bytes (flash) or the low data byte (eeprom) into the buffer slot
    if (pl_rise && agree.byte_select_one)
    begin
      if (r_r.cmd == CMD_WR_FLASH)
      begin
        r_nxt.fbuf[r_r.addr_lo[PAGE_AW-1:0]] =
          {r_r.data_hi, r_r.data_lo};
        r_nxt.fmask[r_r.addr_lo[PAGE_AW-1:0]] = 1'b1;
      end
      else if (r_r.cmd == CMD_WR_EE)
      begin
        r_nxt.ebuf[r_r.addr_lo[EE_PAGE_AW-1:0]] = r_r.data_lo;
        r_nxt.emask[r_r.addr_lo[EE_PAGE_AW-1:0]] = 1'b1;
      end
    end
    // write strobe commits and starts the self-timed busy period
    if (wr_fall)
    begin
      case (r_r.cmd)
        CMD_WR_FLASH:
          if (!agree.byte_select_one)
          begin
            for (int i = 0; i < PAGE_WORDS; i++)
            begin
              fidx = {addr[FLASH_AW-1:PAGE_AW],
                      PAGE_AW'(i)};
              if (r_r.fmask[i])
                r_nxt.flash[fidx] = r_r.fbuf[i];
            end
            // a word latched in this same cycle stays pending
            r_nxt.fmask = r_nxt.fmask & ~r_r.fmask;
            r_nxt.phase = PH_BUSY;
          end
        CMD_WR_EE:
          if (!agree.byte_select_one)
          begin
            for (int i = 0; i < EE_PAGE; i++)
            begin
              eidx = {addr[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(i)};
              if (r_r.emask[i])
                r_nxt.ee[eidx] = r_r.ebuf[i];
            end
            r_nxt.emask = r_nxt.emask & ~r_r.emask;
            r_nxt.phase = PH_BUSY;
          end
        CMD_WR_FUSE:
          if (!agree.byte_select_two)
          begin
            if (agree.byte_select_one)
              r_nxt.fuse_hi = r_r.data_lo;
            else
              r_nxt.fuse_lo = r_r.data_lo;
            r_nxt.phase = PH_BUSY;
          end
        CMD_WR_LOCK:
        begin
          // only zeros stick; reset is the sole way back
          r_nxt.lock = r_r.lock & r_r.data_lo;
          r_nxt.phase = PH_BUSY;
        end
        default: ;
      endcase
      if (r_nxt.phase == PH_BUSY)
        r_nxt.tmr = TMR_W'(WRITE_CYC - 1);
    end
    // busy countdown
    case (r_r.phase)
      PH_BUSY:
        if (r_r.tmr == '0)
          r_nxt.phase = PH_READY;
        else
          r_nxt.tmr = r_r.tmr - 1'b1;
      PH_READY: ;
      default: r_nxt.phase = PH_READY;
    endcase
    // registered bus outputs; the drive enable follows the settled output enable
    r_nxt.dout = rd_byte;
    r_nxt.doe_n = r_r.stab.output_enable_n;
  end

  // state register; memories start erased, fuses and locks unprogrammed
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r_r.s1 <= PINS_IDLE;
      r_r.s2 <= PINS_IDLE;
      r_r.s3 <= PINS_IDLE;
      r_r.stab <= PINS_IDLE;
      r_r.cmd <= CMD_NOP;
      r_r.addr_lo <= 8'h00;
      r_r.addr_hi <= 8'h00;
      r_r.data_lo <= BYTE_ERASED;
      r_r.data_hi <= BYTE_ERASED;
      r_r.fuse_lo <= BYTE_ERASED;
      r_r.fuse_hi <= BYTE_ERASED;
      r_r.lock <= BYTE_ERASED;
      r_r.fbuf <= {PAGE_WORDS{WORD_ERASED}};
      r_r.fmask <= '0;
      r_r.ebuf <= {EE_PAGE{BYTE_ERASED}};
      r_r.emask <= '0;
      r_r.flash <= {FLASH_WORDS{WORD_ERASED}};
      r_r.ee <= {EE_BYTES{BYTE_ERASED}};
      r_r.phase <= PH_READY;
      r_r.tmr <= '0;
      r_r.dout <= BYTE_ERASED;
      r_r.doe_n <= 1'b1;
    end
    else if (CE)
      r_r <= r_nxt;
  end

  assign DATA_OUT = r_r.dout;
  assign DATA_OE_N = r_r.doe_n;
  assign READY_BUSY = idle;

  // checks on load, buffer, write and read behaviour
  chk_cmd_load: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && ls_rise && act == ACT_CMD && !agree.byte_select_one)
    |=> r_r.cmd == $past(agree.data))
    else $error("command byte not loaded");

  chk_addr_lo: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && ls_rise && act == ACT_ADDR && !agree.byte_select_one)
    |=> r_r.addr_lo == $past(agree.data) && $stable(r_r.addr_hi))
    else $error("low address byte not loaded");

  chk_addr_hi: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && ls_rise && act == ACT_ADDR && agree.byte_select_one)
    |=> r_r.addr_hi == $past(agree.data) && $stable(r_r.addr_lo))
    else $error("high address byte not loaded");

  chk_data_hi: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && ls_rise && act == ACT_DATA && agree.byte_select_one)
    |=> r_r.data_hi == $past(agree.data) && $stable(r_r.data_lo))
    else $error("high data byte not loaded");

  chk_page_latch: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && pl_rise && agree.byte_select_one && r_r.cmd == CMD_WR_FLASH)
    |=> r_r.fbuf[$past(r_r.addr_lo[PAGE_AW-1:0])]
        == $past({r_r.data_hi, r_r.data_lo}))
    else $error("page buffer word not latched");

  chk_busy_start: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && wr_fall && r_r.cmd == CMD_WR_FLASH && !agree.byte_select_one)
    |=> !READY_BUSY ##0 r_r.tmr == TMR_W'(WRITE_CYC - 1))
    else $error("flash page write did not go busy");

  chk_busy_end: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && !READY_BUSY && r_r.tmr == '0) |=> READY_BUSY)
    else $error("busy did not end at timer expiry");

  chk_nop_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && ls_rise && act == ACT_CMD && !agree.byte_select_one
     && agree.data == CMD_NOP) |=> r_r.fmask == '0 && r_r.emask == '0)
    else $error("no-operation left buffers pending");

  chk_fuse_low: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && wr_fall && r_r.cmd == CMD_WR_FUSE && !agree.byte_select_one
     && !agree.byte_select_two) |=> r_r.fuse_lo == $past(r_r.data_lo))
    else $error("low fuses not programmed");

  chk_lock_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE |=> (r_r.lock & ~$past(r_r.lock)) == 8'h00)
    else $error("lock bit was cleared");

  chk_flash_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && r_r.cmd == CMD_RD_FLASH && !r_r.stab.byte_select_one)
    |=> DATA_OUT == $past(fword[7:0]))
    else $error("flash low byte not presented");

  chk_bus_drive: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE |=> DATA_OE_N == $past(r_r.stab.output_enable_n))
    else $error("bus drive does not follow output enable");

  chk_busy_ignore: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CE && !READY_BUSY) |=> $stable(r_r.cmd) && $stable(r_r.addr_lo))
    else $error("load accepted while busy");

endmodule

// ---- ppm_prog.sv ----
`timescale 1ns/1ps
module ppm_prog
  import ppm_pkg::*;
(
  // clock and device status
  input  wire logic                clk,
  input  wire logic                ready_busy,
  input  wire logic                data_oe_n,
  input  wire ppm_pkg::ppm_byte_t  data_out,
  // programming pins
  output      ppm_pkg::ppm_pins_s  pins
);

  // pins sit idle until the first task runs
  initial pins = PINS_IDLE;

  // wait n rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // selects settle 4 cycles before the strobe, hold 6 after it falls
  task automatic load(input logic [1:0] act, input logic s1,
                      input ppm_byte_t b);
    pins.action_select_hi <= act[1];
    pins.action_select_lo <= act[0];
    pins.byte_select_one  <= s1;
    pins.data             <= b;
    tick(4);
    pins.load_strobe <= 1'b1;
    tick(6);
    pins.load_strobe <= 1'b0;
    tick(6);
    pins.action_select_hi <= 1'b1;
    pins.action_select_lo <= 1'b1;
    tick(1);
  endtask

  // latch needs select one high around the pulse
  task automatic latch();
    pins.byte_select_one <= 1'b1;
    tick(4);
    pins.page_load_pulse <= 1'b1;
    tick(6);
    pins.page_load_pulse <= 1'b0;
    tick(6);
  endtask

  // write strobe; busy counted at falling edges, where it has settled
  task automatic write(input logic s1, input logic s2, output int busy);
    int n;
    pins.byte_select_one <= s1;
    pins.byte_select_two <= s2;
    tick(4);
    pins.write_strobe_n <= 1'b0;
    busy = 0;
    for (int k = 1; k <= 60; k++)
    begin
      tick(1);
      if (k == 6)
        pins.write_strobe_n <= 1'b1;
      @(negedge clk);
      if (ready_busy === 1'b0)
        busy++;
    end
    n = 0;
    while (ready_busy !== 1'b1 && n < 1000)
    begin
      tick(1);
      n++;
    end
    tick(1);
    pins.byte_select_one <= 1'b0;
    pins.byte_select_two <= 1'b0;
    tick(1);
  endtask

  // read with enable low, then release; oe = {while low, after release}
  task automatic read(input logic s1, input logic s2,
                      output ppm_byte_t d, output logic [1:0] oe);
    pins.byte_select_one <= s1;
    pins.byte_select_two <= s2;
    pins.output_enable_n <= 1'b0;
    tick(10);
    @(negedge clk);
    d     = data_out;
    oe[1] = data_oe_n;
    tick(1);
    pins.output_enable_n <= 1'b1;
    tick(10);
    @(negedge clk);
    oe[0] = data_oe_n;
    tick(1);
  endtask

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import ppm_pkg::*;

  localparam logic [7:0] SIG0 = 8'h3c; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h4d; // arbitrary value
  localparam logic [7:0] SIG2 = 8'h5e; // arbitrary value
  localparam logic [7:0] CAL  = 8'h7b; // arbitrary value

  logic      clk   = 1'b0;
  logic      rst_n = 1'b0;
  logic      ready_busy;
  logic      oe_n;
  ppm_byte_t dout;
  ppm_byte_t din;
  ppm_pins_s pins;
  int        n_fail = 0;
  int        checks = 0;

  always #5 clk = ~clk;

  // device owns the bus while its enable is low
  assign din = (oe_n === 1'b0) ? dout : pins.data;

  ppm_port #(.WRITE_CYC(20), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
             .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) dut_u (
    .CLK(clk), .RESET_N(rst_n), .CE(1'b1),
    .LOAD_STROBE(pins.load_strobe), .PAGE_LOAD_PULSE(pins.page_load_pulse),
    .WRITE_STROBE_N(pins.write_strobe_n),
    .OUTPUT_ENABLE_N(pins.output_enable_n),
    .BYTE_SELECT_ONE(pins.byte_select_one),
    .BYTE_SELECT_TWO(pins.byte_select_two),
    .ACTION_SELECT_HI(pins.action_select_hi),
    .ACTION_SELECT_LO(pins.action_select_lo),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .READY_BUSY(ready_busy));

  ppm_prog prog_u (.clk(clk), .ready_busy(ready_busy), .data_oe_n(oe_n),
                   .data_out(dout), .pins(pins));

  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string w, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask

  // one read, with the bus enable judged on the way in and out
  task automatic rd(input string w, input logic s1, s2,
                    input ppm_byte_t e);
    ppm_byte_t d;
    logic [1:0] oe;
    prog_u.read(s1, s2, d, oe);
    check(w, {8'h00, d}, {8'h00, e});
    check("bus_enable", {14'h0, oe}, 16'h0001);
  endtask

  task automatic wr(input string w, input logic s1, s2);
    int b;
    prog_u.write(s1, s2, b);
    check(w, b[15:0], 16'd20);
  endtask

  // idle state after reset
  task automatic t_reset();
    check("ready", {15'h0, ready_busy}, 16'h0001);
    check("oe", {15'h0, oe_n}, 16'h0001);
  endtask

  // flash page with an aborted latch, a page-end word, then read back
  task automatic t_flash();
    logic [7:0]  lo [3] = '{8'h20, 8'h3f, 8'h22};
    logic [15:0] wd [3] = '{16'h1234, 16'habcd, 16'hffff};
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    prog_u.load(ACT_ADDR, 1'b1, 8'h01);
    prog_u.load(ACT_ADDR, 1'b0, 8'h22);
    prog_u.load(ACT_DATA, 1'b0, 8'h55);
    prog_u.latch();
    prog_u.load(ACT_CMD, 1'b0, CMD_NOP);
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    for (int i = 0; i < 2; i++)
    begin
      prog_u.load(ACT_ADDR, 1'b0, lo[i]);
      prog_u.load(ACT_DATA, 1'b0, wd[i][7:0]);
      prog_u.load(ACT_DATA, 1'b1, wd[i][15:8]);
      prog_u.latch();
    end
    wr("flash_busy", 1'b0, 1'b0);
    prog_u.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    for (int i = 0; i < 3; i++)
    begin
      prog_u.load(ACT_ADDR, 1'b0, lo[i]);
      rd("flash_lo", 1'b0, 1'b0, wd[i][7:0]);
      rd("flash_hi", 1'b1, 1'b0, wd[i][15:8]);
    end
  endtask

  // two bytes of one eeprom page, one untouched neighbour
  task automatic t_ee();
    logic [7:0] lo [3] = '{8'h05, 8'h06, 8'h07};
    logic [7:0] db [3] = '{8'ha5, 8'h3c, 8'hff};
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_EE);
    prog_u.load(ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      prog_u.load(ACT_ADDR, 1'b0, lo[i]);
      prog_u.load(ACT_DATA, 1'b0, db[i]);
      prog_u.latch();
    end
    wr("ee_busy", 1'b0, 1'b0);
    prog_u.load(ACT_CMD, 1'b0, CMD_RD_EE);
    for (int i = 0; i < 3; i++)
    begin
      prog_u.load(ACT_ADDR, 1'b0, lo[i]);
      rd("ee_byte", 1'b0, 1'b0, db[i]);
    end
  endtask

  // fuses low and high, locks can only be programmed further
  task automatic t_fuse();
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    prog_u.load(ACT_DATA, 1'b0, 8'he1);
    wr("fuse_lo_busy", 1'b0, 1'b0);
    prog_u.load(ACT_DATA, 1'b0, 8'h9d);
    wr("fuse_hi_busy", 1'b1, 1'b0);
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    prog_u.load(ACT_DATA, 1'b0, 8'hfc);
    wr("lock_busy", 1'b0, 1'b0);
    prog_u.load(ACT_DATA, 1'b0, 8'hff);
    wr("lock_busy", 1'b0, 1'b0);
    prog_u.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd("fuse_lo", 1'b0, 1'b0, 8'he1);
    rd("fuse_hi", 1'b1, 1'b1, 8'h9d);
    rd("lock", 1'b1, 1'b0, 8'hfc);
  endtask

  // an address load issued while a lock write is busy must be refused
  task automatic t_busy();
    prog_u.load(ACT_ADDR, 1'b0, 8'h11);
    prog_u.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    prog_u.load(ACT_DATA, 1'b0, 8'hff);
    fork
      wr("busy_len", 1'b0, 1'b0);
      begin
        prog_u.tick(4);
        prog_u.load(ACT_ADDR, 1'b0, 8'h01);
      end
    join
    prog_u.load(ACT_CMD, 1'b0, CMD_RD_SIG);
    rd("busy_ignore", 1'b0, 1'b0, BYTE_ERASED);
  endtask

  // signature row and calibration byte
  task automatic t_sig();
    logic [7:0] sig [3] = '{SIG0, SIG1, SIG2};
    prog_u.load(ACT_CMD, 1'b0, CMD_RD_SIG);
    for (int i = 0; i < 3; i++)
    begin
      prog_u.load(ACT_ADDR, 1'b0, i[7:0]);
      rd("sig", 1'b0, 1'b0, sig[i]);
    end
    prog_u.load(ACT_ADDR, 1'b0, CAL_ADDR);
    rd("cal", 1'b1, 1'b0, CAL);
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_flash();
    t_ee();
    t_fuse();
    t_busy();
    t_sig();
    test_done();
  end

  // hang guard, well beyond the under two thousand cycles needed
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done();
  end

endmodule
